// ---- core/playback_cfg_pkg.sv ----
package playback_cfg_pkg;
  localparam int SAMPLE_W = 16;
  localparam logic [7:0] LIMIT_ROUTE_ADDR = 8'h23;
  localparam logic [7:0] GAIN_COMP_ADDR = 8'h24;
  localparam logic [7:0] SUPPLY_LIMIT_ADDR = 8'h2b;
  localparam logic [7:0] MIXER_ADDR = 8'h2c;
  localparam logic [7:0] PROTECT_ADDR = 8'h2d;
  localparam logic [7:0] UNDERVOLT_ADDR = 8'h2e;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] UNDERVOLT_RESET = 8'hbf;
  // Writable bits per register; reserved positions are never stored.
  localparam logic [7:0] LIMIT_ROUTE_MASK = 8'hf0;
  localparam logic [7:0] GAIN_COMP_MASK = 8'hff;
  localparam logic [7:0] SUPPLY_LIMIT_MASK = 8'hfc;
  localparam logic [7:0] MIXER_MASK = 8'hf0;
  localparam logic [7:0] PROTECT_MASK = 8'hef;
  localparam logic [7:0] UNDERVOLT_MASK = 8'hff;
  localparam int DETECT_LO = 6;
  localparam int APPLY_LO = 4;
  localparam int LIMITER_ON_BIT = 7;
  localparam int ATTEN_LO = 4;
  localparam int SENSED_BIT = 3;
  localparam int RELEASE_BIT = 2;
  localparam int AUTO_GAIN_LO = 4;
  localparam int COMPRESS_LO = 0;
  localparam int MIXER_LO = 4;
  localparam int DISTORT_BIT = 7;
  localparam int BATTERY_BIT = 6;
  localparam int HEAT_BIT = 5;
  localparam int GEN_ONE_BIT = 3;
  localparam int GEN_TWO_BIT = 2;
  localparam int ROUTE_BIT = 1;
  localparam int CUTOFF_BIT = 0;
  localparam int ATTEN_LEVELS = 7;
  // Sensed supply below each level adds one 6 dB attenuation step.
  localparam logic [7:0] ATTEN_LEVEL [ATTEN_LEVELS] =
    '{8'hc0, 8'hb0, 8'ha0, 8'h90, 8'h80, 8'h70, 8'h60};
  typedef enum logic [1:0] {DET_MAX, DET_ONE, DET_ZERO, DET_AVG} detect_src_t;
  typedef enum logic [1:0] {APP_BOTH, APP_ONE, APP_ZERO, APP_NONE} apply_t;
  typedef struct packed {
    logic [7:0] limit_route;
    logic [7:0] gain_comp;
    logic [7:0] supply_limit;
    logic [7:0] mixer;
    logic [7:0] protect;
    logic [7:0] undervolt;
  } cfg_regs_t;
  typedef struct packed {
    logic [3:0] auto_gain_on;
    logic [3:0] range_compress_on;
    logic [3:0] mixer_on;
    logic distortion_on;
    logic battery_guard_on;
    logic heat_foldback_on;
    logic gen_one_on;
    logic gen_two_on;
  } enables_t;
endpackage

// ---- core/limiter_route.sv ----
`timescale 1ns/10ps
module limiter_route
  import playback_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic signed [SAMPLE_W-1:0] playback_input_zero,
  input wire logic signed [SAMPLE_W-1:0] playback_input_one,
  input wire detect_src_t limiter_detect_source,
  input wire apply_t limiter_apply_target,
  output logic signed [SAMPLE_W-1:0] detect_sample,
  output logic apply_zero,
  output logic apply_one
);
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] det;
    logic app_zero;
    logic app_one;
  } route_state_t;
  route_state_t st, next_st;
  logic signed [SAMPLE_W:0] sum;

  always_comb begin
    next_st = st;
    sum = (SAMPLE_W+1)'(playback_input_zero) +
      (SAMPLE_W+1)'(playback_input_one);
    case (limiter_detect_source)
      DET_MAX: next_st.det = (playback_input_zero > playback_input_one) ?
        playback_input_zero : playback_input_one;
      DET_ONE: next_st.det = playback_input_one;
      DET_ZERO: next_st.det = playback_input_zero;
      default: next_st.det = sum[SAMPLE_W:1];
    endcase
    next_st.app_zero = (limiter_apply_target == APP_BOTH) ||
      (limiter_apply_target == APP_ZERO);
    next_st.app_one = (limiter_apply_target == APP_BOTH) ||
      (limiter_apply_target == APP_ONE);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign detect_sample = st.det;
  assign apply_zero = st.app_zero;
  assign apply_one = st.app_one;
endmodule // limiter_route

// ---- core/supply_limit_atten.sv ----
`timescale 1ns/10ps
module supply_limit_atten
  import playback_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic power_limiter_on,
  input wire logic attenuation_from_sensed_voltage,
  input wire logic attenuation_release_on,
  input wire logic [2:0] power_limiter_attenuation,
  input wire logic limit_pin,
  input wire logic [7:0] sensed_supply,
  output logic [2:0] atten_step
);
  typedef struct packed {
    logic [2:0] atten;
  } atten_state_t;
  atten_state_t st, next_st;
  logic [ATTEN_LEVELS-1:0] below;
  logic [2:0] target;

  for (genvar i = 0; i < ATTEN_LEVELS; i++) begin : g_level
    assign below[i] = sensed_supply < ATTEN_LEVEL[i];
  end

  always_comb begin
    next_st = st;
    if (attenuation_from_sensed_voltage) begin
      target = 3'($countones(below));
    end else begin
      target = limit_pin ? power_limiter_attenuation : 3'h0;
    end
    if (!power_limiter_on) begin
      next_st.atten = 3'h0;
    end else if (attenuation_release_on || target > st.atten) begin
      next_st.atten = target;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign atten_step = st.atten;
endmodule // supply_limit_atten

// ---- core/playback_protect_regs.sv ----
// Notes on behaviour
// - Detect source: 0 max, 1 input one, 2 input zero, 3 average.
// - Limiter gain applied: 0 both, 1 input one, 2 input zero, 3 none.
// - Bits 7 to 4 enable auto gain on channels one to four.
// - Bits 3 to 0 enable range compression on channels one to four.
// - Power limiter runs on bit 7; bits 6-4 give 6 dB steps.
// - Bit 3 clear uses pin and field; set uses sensed voltage table.
// - Without release bit, attenuation drops only when bit 7 clears; with it, it may recover.
// - Bits 7 to 4 enable the four internal mixers.
// - Distortion limiter runs only while protection bit 7 is one.
// - Battery protection runs only while protection bit 6 is one.
// - Thermal foldback runs only while protection bit 5 is one.
// - Generators one and two enabled by bits 3 and 2.
// - Bit 1 routes supply samples to processing; zero is reserved.
// - Undervolt cutoff enabled only while protection bit 0 is one.
// - Undervolt level resets to 0xbf; the other registers to zero.
// - Undervolt level is eight bits compared with the sensed supply.
`timescale 1ns/10ps
module playback_protect_regs (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic signed [playback_cfg_pkg::SAMPLE_W-1:0] playback_input_zero,
  input wire logic signed [playback_cfg_pkg::SAMPLE_W-1:0] playback_input_one,
  input wire logic limit_pin,
  input wire logic [7:0] sensed_supply,
  output logic signed [playback_cfg_pkg::SAMPLE_W-1:0] detect_sample,
  output logic apply_zero,
  output logic apply_one,
  output logic [2:0] atten_step,
  output playback_cfg_pkg::enables_t enables,
  output logic supply_sample_route,
  output logic undervolt_shutdown
);
  import playback_cfg_pkg::*;

  typedef struct packed {
    cfg_regs_t regs;
    logic [1:0] pin_sync;
    logic [7:0] rdata;
    logic cutoff;
  } bank_state_t;

  bank_state_t st, next_st;
  logic hit_limit, hit_gain, hit_supply, hit_mixer, hit_protect, hit_uv;

  assign hit_limit = reg_wr && reg_addr == LIMIT_ROUTE_ADDR;
  assign hit_gain = reg_wr && reg_addr == GAIN_COMP_ADDR;
  assign hit_supply = reg_wr && reg_addr == SUPPLY_LIMIT_ADDR;
  assign hit_mixer = reg_wr && reg_addr == MIXER_ADDR;
  assign hit_protect = reg_wr && reg_addr == PROTECT_ADDR;
  assign hit_uv = reg_wr && reg_addr == UNDERVOLT_ADDR;

  always_comb begin
    next_st = st;
    // Masking on write keeps reserved positions at zero whatever is sent.
    if (hit_limit) begin
      next_st.regs.limit_route = reg_wdata & LIMIT_ROUTE_MASK;
    end
    if (hit_gain) begin
      next_st.regs.gain_comp = reg_wdata & GAIN_COMP_MASK;
    end
    if (hit_supply) begin
      next_st.regs.supply_limit = reg_wdata & SUPPLY_LIMIT_MASK;
    end
    if (hit_mixer) begin
      next_st.regs.mixer = reg_wdata & MIXER_MASK;
    end
    if (hit_protect) begin
      next_st.regs.protect = reg_wdata & PROTECT_MASK;
    end
    if (hit_uv) begin
      next_st.regs.undervolt = reg_wdata & UNDERVOLT_MASK;
    end
    // The pin is asynchronous, so it passes two flops first.
    next_st.pin_sync = {st.pin_sync[0], limit_pin};
    case (reg_addr)
      LIMIT_ROUTE_ADDR: next_st.rdata = st.regs.limit_route;
      GAIN_COMP_ADDR: next_st.rdata = st.regs.gain_comp;
      SUPPLY_LIMIT_ADDR: next_st.rdata = st.regs.supply_limit;
      MIXER_ADDR: next_st.rdata = st.regs.mixer;
      PROTECT_ADDR: next_st.rdata = st.regs.protect;
      UNDERVOLT_ADDR: next_st.rdata = st.regs.undervolt;
      default: next_st.rdata = 8'h00;
    endcase
    next_st.cutoff = st.regs.protect[CUTOFF_BIT] &&
      sensed_supply < st.regs.undervolt;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st.regs.limit_route <= ZERO_RESET;
      st.regs.gain_comp <= ZERO_RESET;
      st.regs.supply_limit <= ZERO_RESET;
      st.regs.mixer <= ZERO_RESET;
      st.regs.protect <= ZERO_RESET;
      st.regs.undervolt <= UNDERVOLT_RESET;
      st.pin_sync <= 2'h0;
      st.rdata <= 8'h00;
      st.cutoff <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign undervolt_shutdown = st.cutoff;
  assign enables.auto_gain_on =
    st.regs.gain_comp[AUTO_GAIN_LO +: 4];
  assign enables.range_compress_on =
    st.regs.gain_comp[COMPRESS_LO +: 4];
  assign enables.mixer_on = st.regs.mixer[MIXER_LO +: 4];
  assign enables.distortion_on = st.regs.protect[DISTORT_BIT];
  assign enables.battery_guard_on = st.regs.protect[BATTERY_BIT];
  assign enables.heat_foldback_on = st.regs.protect[HEAT_BIT];
  assign enables.gen_one_on = st.regs.protect[GEN_ONE_BIT];
  assign enables.gen_two_on = st.regs.protect[GEN_TWO_BIT];
  // Zero here is reserved; the path is simply left unrouted then.
  assign supply_sample_route = st.regs.protect[ROUTE_BIT];

  limiter_route u_route (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .playback_input_zero(playback_input_zero),
    .playback_input_one(playback_input_one),
    .limiter_detect_source(
      detect_src_t'(st.regs.limit_route[DETECT_LO +: 2])),
    .limiter_apply_target(
      apply_t'(st.regs.limit_route[APPLY_LO +: 2])),
    .detect_sample(detect_sample),
    .apply_zero(apply_zero),
    .apply_one(apply_one)
  );

  supply_limit_atten u_atten (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .power_limiter_on(st.regs.supply_limit[LIMITER_ON_BIT]),
    .attenuation_from_sensed_voltage(
      st.regs.supply_limit[SENSED_BIT]),
    .attenuation_release_on(st.regs.supply_limit[RELEASE_BIT]),
    .power_limiter_attenuation(st.regs.supply_limit[ATTEN_LO +: 3]),
    .limit_pin(st.pin_sync[1]),
    .sensed_supply(sensed_supply),
    .atten_step(atten_step)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  logic pl_on, pl_sensed, pl_release;
  logic [2:0] pl_code;
  assign pl_on = st.regs.supply_limit[LIMITER_ON_BIT];
  assign pl_sensed = st.regs.supply_limit[SENSED_BIT];
  assign pl_release = st.regs.supply_limit[RELEASE_BIT];
  assign pl_code = st.regs.supply_limit[ATTEN_LO +: 3];
  logic mapped;
  logic signed [SAMPLE_W:0] pair_sum;
  assign mapped = reg_addr inside {LIMIT_ROUTE_ADDR, GAIN_COMP_ADDR,
    SUPPLY_LIMIT_ADDR, MIXER_ADDR, PROTECT_ADDR, UNDERVOLT_ADDR};
  // Seventeen bits keep the sum of two full scale samples from wrapping.
  assign pair_sum = (SAMPLE_W+1)'(playback_input_zero) +
    (SAMPLE_W+1)'(playback_input_one);

  sequence s_write(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  sequence s_read(logic [7:0] a);
    !reg_wr && reg_addr == a;
  endsequence

  a_reset_values:
    assert property (disable iff (1'b0) !nrst |=>
      st.regs.undervolt == UNDERVOLT_RESET &&
      st.regs.limit_route == ZERO_RESET &&
      st.regs.gain_comp == ZERO_RESET &&
      st.regs.supply_limit == ZERO_RESET &&
      st.regs.mixer == ZERO_RESET && st.regs.protect == ZERO_RESET)
    else $error("register bank left reset with wrong values");

  a_reserved_zero:
    assert property (s_write(LIMIT_ROUTE_ADDR) ##1 s_read(LIMIT_ROUTE_ADDR)
      |=> reg_rdata[3:0] == 4'h0 &&
        reg_rdata[7:4] == $past(reg_wdata[7:4], 2))
    else $error("limiter routing readback wrong or reserved bits set");

  a_protect_readback:
    assert property (s_write(PROTECT_ADDR) ##1 s_read(PROTECT_ADDR)
      |=> reg_rdata == ($past(reg_wdata, 2) & PROTECT_MASK))
    else $error("protection readback differs from masked write");

  // Checks sample registered state, so each one but a_pin_sync looks an edge after its cause.
  a_unmapped_zero:
    assert property (!mapped |=> reg_rdata == 8'h00)
    else $error("unmapped address returned nonzero data");

  a_write_ignored:
    assert property (reg_wr && !mapped |=> st.regs == $past(st.regs))
    else $error("write to unmapped address changed a register");

  a_supply_readback:
    assert property (s_write(SUPPLY_LIMIT_ADDR) ##1
      s_read(SUPPLY_LIMIT_ADDR)
      |=> reg_rdata == ($past(reg_wdata, 2) & SUPPLY_LIMIT_MASK))
    else $error("power limiter readback differs from masked write");

  a_mixer_readback:
    assert property (s_write(MIXER_ADDR) ##1 s_read(MIXER_ADDR)
      |=> reg_rdata == ($past(reg_wdata, 2) & MIXER_MASK))
    else $error("mixer readback differs from masked write");

  a_level_readback:
    assert property (s_write(UNDERVOLT_ADDR) ##1 s_read(UNDERVOLT_ADDR)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("undervolt level readback differs from write");

  a_reset_outputs:
    assert property (disable iff (1'b0) !nrst |=>
      atten_step == 3'h0 && !undervolt_shutdown && reg_rdata == 8'h00)
    else $error("outputs left reset with wrong values");

  a_detect_zero:
    assert property (st.regs.limit_route[DETECT_LO +: 2] == DET_ZERO
      |=> detect_sample == $past(playback_input_zero))
    else $error("detect sample not taken from input zero");

  a_detect_avg:
    assert property (st.regs.limit_route[DETECT_LO +: 2] == DET_AVG
      |=> detect_sample == ($past(pair_sum) >>> 1))
    else $error("detect sample is not the rounded down average");

  a_apply_both:
    assert property (nrst && st.regs.limit_route[APPLY_LO +: 2] == APP_BOTH
      |=> apply_zero && apply_one)
    else $error("limiter gain not applied to both inputs");

  a_apply_zero_only:
    assert property (st.regs.limit_route[APPLY_LO +: 2] == APP_ZERO
      |=> apply_zero && !apply_one)
    else $error("limiter gain not confined to input zero");

  a_sensed_top:
    assert property (pl_on && pl_sensed && pl_release &&
      sensed_supply >= ATTEN_LEVEL[0] |=> atten_step == 3'h0)
    else $error("healthy sensed supply still attenuated");

  a_pin_sync:
    assert property ($past(nrst, 2)
      |-> st.pin_sync[1] == $past(limit_pin, 2))
    else $error("limit pin did not pass exactly two flops");

  a_release_hold:
    assert property (pl_on && !pl_release && !pl_sensed && st.pin_sync[1]
      |=> atten_step >= $past(pl_code))
    else $error("attenuation fell below the pin requested step");

  a_detect_pick:
    assert property (st.regs.limit_route[DETECT_LO +: 2] == DET_ONE
      |=> detect_sample == $past(playback_input_one))
    else $error("detect sample not taken from input one");

  a_detect_max:
    assert property (st.regs.limit_route[DETECT_LO +: 2] == DET_MAX &&
      playback_input_zero > playback_input_one
      |=> detect_sample == $past(playback_input_zero))
    else $error("detect sample is not the larger input");

  a_apply_route:
    assert property (st.regs.limit_route[APPLY_LO +: 2] == APP_NONE
      ##1 st.regs.limit_route[APPLY_LO +: 2] == APP_NONE
      |-> !apply_zero && !apply_one)
    else $error("limiter gain applied while routed to none");

  a_apply_one_only:
    assert property (st.regs.limit_route[APPLY_LO +: 2] == APP_ONE
      |=> apply_one && !apply_zero)
    else $error("limiter gain not confined to input one");

  a_gain_write:
    assert property (s_write(GAIN_COMP_ADDR)
      |=> enables.auto_gain_on == $past(reg_wdata[7:4]))
    else $error("auto gain enables do not follow the write");

  a_compress_write:
    assert property (s_write(GAIN_COMP_ADDR)
      |=> enables.range_compress_on == $past(reg_wdata[3:0]))
    else $error("compression enables do not follow the write");

  a_limiter_off:
    assert property (!pl_on |=> atten_step == 3'h0)
    else $error("attenuation applied while power limiter off");

  a_pin_code:
    assert property (pl_on && !pl_sensed && pl_release && st.pin_sync[1]
      |=> atten_step == $past(pl_code))
    else $error("pin driven attenuation not the programmed step");

  a_pin_idle:
    assert property (pl_on && !pl_sensed && pl_release && !st.pin_sync[1]
      |=> atten_step == 3'h0)
    else $error("attenuation kept although pin released");

  a_sensed_floor:
    assert property (pl_on && pl_sensed && pl_release &&
      sensed_supply < ATTEN_LEVEL[ATTEN_LEVELS-1]
      |=> atten_step == 3'(ATTEN_LEVELS))
    else $error("lowest sensed supply did not give full attenuation");

  a_atten_hold:
    assert property (pl_on && !pl_release ##1 pl_on && !pl_release
      |-> atten_step >= $past(atten_step))
    else $error("attenuation dropped without release enabled");

  a_mixer_write:
    assert property (s_write(MIXER_ADDR)
      |=> enables.mixer_on == $past(reg_wdata[7:4]))
    else $error("mixer enables do not follow the write");

  a_misc_enables:
    assert property (s_write(PROTECT_ADDR) |=>
      enables.distortion_on == $past(reg_wdata[DISTORT_BIT]) &&
      enables.battery_guard_on == $past(reg_wdata[BATTERY_BIT]) &&
      enables.heat_foldback_on == $past(reg_wdata[HEAT_BIT]) &&
      enables.gen_one_on == $past(reg_wdata[GEN_ONE_BIT]) &&
      enables.gen_two_on == $past(reg_wdata[GEN_TWO_BIT]))
    else $error("protection enables do not follow the write");

  a_route_write:
    assert property (s_write(PROTECT_ADDR)
      |=> supply_sample_route == $past(reg_wdata[ROUTE_BIT]))
    else $error("supply sample routing does not follow the write");

  a_cutoff_trip:
    assert property (st.regs.protect[CUTOFF_BIT] &&
      sensed_supply < st.regs.undervolt |=> undervolt_shutdown)
    else $error("undervolt cutoff missed a low supply");

  a_cutoff_off:
    assert property (!st.regs.protect[CUTOFF_BIT] ||
      sensed_supply >= st.regs.undervolt |=> !undervolt_shutdown)
    else $error("undervolt cutoff raised without cause");
endmodule // playback_protect_regs

// ---- tb/playback_protection_config_regs_tb.sv ----
`timescale 1ns/10ps
module playback_protection_config_regs_tb;
  import playback_cfg_pkg::*;
  logic ref_clk;
  logic nrst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic signed [SAMPLE_W-1:0] in_zero;
  logic signed [SAMPLE_W-1:0] in_one;
  logic limit_pin;
  logic [7:0] sensed_supply;
  logic signed [SAMPLE_W-1:0] detect_sample;
  logic apply_zero;
  logic apply_one;
  logic [2:0] atten_step;
  enables_t enables;
  logic supply_sample_route;
  logic undervolt_shutdown;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] addrs [6] = '{LIMIT_ROUTE_ADDR, GAIN_COMP_ADDR,
    SUPPLY_LIMIT_ADDR, MIXER_ADDR, PROTECT_ADDR, UNDERVOLT_ADDR};
  logic [7:0] masks [6] = '{LIMIT_ROUTE_MASK, GAIN_COMP_MASK,
    SUPPLY_LIMIT_MASK, MIXER_MASK, PROTECT_MASK, UNDERVOLT_MASK};
  logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hbf};

  playback_protect_regs DUT (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .playback_input_zero(in_zero),
    .playback_input_one(in_one),
    .limit_pin(limit_pin),
    .sensed_supply(sensed_supply),
    .detect_sample(detect_sample),
    .apply_zero(apply_zero),
    .apply_one(apply_one),
    .atten_step(atten_step),
    .enables(enables),
    .supply_sample_route(supply_sample_route),
    .undervolt_shutdown(undervolt_shutdown)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data follows the address by one edge, so sample just after it.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    #1;
    chk(24'(reg_rdata), 24'(e));
  endtask

  task automatic ws(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) rd(addrs[i], rstv[i]);
    rd(8'h25, 8'h00);
    chk(24'({enables, supply_sample_route, undervolt_shutdown}), 24'h0);
    chk(24'(atten_step), 24'h0);
    $display("test reset done");
  endtask

  task automatic t_regs();
    // Bit 1 of every pattern is set, as zero is reserved for supply routing.
    logic [7:0] pat [3] = '{8'ha7, 8'h5a, 8'hff};
    logic [7:0] p;
    foreach (pat[k]) begin
      p = pat[k];
      for (int i = 0; i < 6; i++) wr(addrs[i], p & masks[i]);
      wr(8'h25, ~p);
      for (int i = 0; i < 6; i++) rd(addrs[i], p & masks[i]);
      chk(24'(enables.auto_gain_on), 24'(p[7:4]));
      chk(24'(enables.range_compress_on), 24'(p[3:0]));
      chk(24'(enables.mixer_on), 24'(p[7:4]));
      chk(24'(enables.distortion_on), 24'(p[7]));
      chk(24'(enables.battery_guard_on), 24'(p[6]));
      chk(24'(enables.heat_foldback_on), 24'(p[5]));
      chk(24'({enables.gen_one_on, enables.gen_two_on}), 24'(p[3:2]));
      chk(24'(supply_sample_route), 24'(p[1]));
    end
    $display("test register map done");
  endtask

  task automatic t_detect();
    logic [15:0] dexp [4] = '{16'h0100, 16'hffb0, 16'h0100, 16'h0058};
    logic [1:0] aexp [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
    @(posedge ref_clk);
    in_zero <= 16'h0100;
    in_one <= 16'hffb0;
    for (int c = 0; c < 4; c++) begin
      wr(LIMIT_ROUTE_ADDR, {2'(c), 2'(c), 4'h0});
      ws(3);
      chk({8'h00, detect_sample}, 24'(dexp[c]));
      chk(24'({apply_zero, apply_one}), 24'(aexp[c]));
    end
    $display("test limiter routing done");
  endtask

  // The pin passes a two-flop synchroniser, hence the longer waits.
  task automatic t_atten_pin();
    wr(SUPPLY_LIMIT_ADDR, 8'hb0);
    limit_pin <= 1'b1;
    ws(5);
    chk(24'(atten_step), 24'h3);
    @(posedge ref_clk);
    limit_pin <= 1'b0;
    ws(5);
    chk(24'(atten_step), 24'h3);
    wr(SUPPLY_LIMIT_ADDR, 8'hb4);
    ws(3);
    chk(24'(atten_step), 24'h0);
    wr(SUPPLY_LIMIT_ADDR, 8'hf4);
    limit_pin <= 1'b1;
    ws(5);
    chk(24'(atten_step), 24'h7);
    wr(SUPPLY_LIMIT_ADDR, 8'h74);
    ws(3);
    chk(24'(atten_step), 24'h0);
    @(posedge ref_clk);
    limit_pin <= 1'b0;
    $display("test pin attenuation done");
  endtask

  task automatic t_atten_sensed();
    logic [7:0] sv [5] = '{8'hc0, 8'hbf, 8'h90, 8'h60, 8'h5f};
    logic [2:0] ae [5] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h7};
    wr(SUPPLY_LIMIT_ADDR, 8'h8c);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      sensed_supply <= sv[i];
      ws(3);
      chk(24'(atten_step), 24'(ae[i]));
    end
    wr(SUPPLY_LIMIT_ADDR, 8'h88);
    sensed_supply <= 8'hff;
    ws(3);
    chk(24'(atten_step), 24'h7);
    wr(SUPPLY_LIMIT_ADDR, 8'h8c);
    ws(3);
    chk(24'(atten_step), 24'h0);
    wr(SUPPLY_LIMIT_ADDR, 8'h08);
    sensed_supply <= 8'h5f;
    ws(3);
    chk(24'(atten_step), 24'h0);
    @(posedge ref_clk);
    sensed_supply <= 8'hff;
    $display("test sensed attenuation done");
  endtask

  task automatic t_undervolt();
    wr(UNDERVOLT_ADDR, 8'h80);
    wr(PROTECT_ADDR, 8'h03);
    sensed_supply <= 8'h7f;
    ws(2);
    chk(24'(undervolt_shutdown), 24'h1);
    @(posedge ref_clk);
    sensed_supply <= 8'h80;
    ws(2);
    chk(24'(undervolt_shutdown), 24'h0);
    @(posedge ref_clk);
    sensed_supply <= 8'h7f;
    wr(PROTECT_ADDR, 8'h02);
    ws(2);
    chk(24'(undervolt_shutdown), 24'h0);
    @(posedge ref_clk);
    sensed_supply <= 8'hff;
    $display("test undervolt cutoff done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    in_zero = 16'h0000;
    in_one = 16'h0000;
    limit_pin = 1'b0;
    sensed_supply = 8'hff;
    t_reset();
    t_regs();
    // A second reset with every register loaded proves the clear.
    t_reset();
    t_detect();
    t_atten_pin();
    t_atten_sensed();
    t_undervolt();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_sim();
  end
endmodule // playback_protection_config_regs_tb
